// file: design/level_detector_map.svh
`ifndef LEVEL_DETECTOR_MAP_SVH
`define LEVEL_DETECTOR_MAP_SVH

`define LD_DATA_W        16
`define LD_COEF_W        16
`define LD_CLK_HZ        25000000
`define LD_SRQ_LEN       6
`define LD_POL_LEN       4
`define LD_CHAR_CR       8'h0D
`define LD_CHAR_LF       8'h0A
`define LD_CHAR_AMP      8'h26
`define LD_COEF_FULL     16'hFFFF
`define LD_PEAK_FALL_DEF 16'h0010
`define LD_MEAN_DEF      16'h0400
`define LD_FALL_DEF      16'h0400
`define LD_RISE_DEF      16'h0400

`endif

// file: design/level_detector_pkg.sv
package level_detector_pkg;
    typedef enum logic [1:0] {
        LAW_REALTIME,
        LAW_PEAK,
        LAW_LINEAR_MEAN,
        LAW_POWER_MEAN
    } law_t;
endpackage : level_detector_pkg

// file: design/exp_smoother.sv
`include "level_detector_map.svh"

module exp_smoother #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         sys_rst,
    // Control
    input  wire logic         clear,
    input  wire logic         sampleValid,
    input  wire logic [W-1:0] sampleIn,
    input  wire logic [15:0]  riseCoef,
    input  wire logic [15:0]  fallCoef,
    // Result
    output logic      [W-1:0] smoothOut
);
    logic [W-1:0]  state_r;
    logic          rising;
    logic [W-1:0]  diff;
    logic [15:0]   coef;
    logic [W+15:0] step;

    // First-order recursion y += k*(x-y); coefficient from rise or fall
    always_comb begin
        rising = sampleIn >= state_r;                               // RQ19
        diff   = rising ? sampleIn - state_r : state_r - sampleIn;
        coef   = rising ? riseCoef : fallCoef;                       // RQ1
        step   = ({16'h0000, diff} * {{W{1'b0}}, coef}) >> 16;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || clear) begin
            state_r <= '0;
        end else if (sampleValid) begin
            // Full coefficient means zero time constant: jump straight to input
            if (coef == `LD_COEF_FULL)
                state_r <= sampleIn;
            else if (rising)
                state_r <= state_r + step[W-1:0];                  // RQ1
            else
                state_r <= state_r - step[W-1:0];                  // RQ1
        end
    end

    assign smoothOut = state_r;
endmodule : exp_smoother

// file: design/level_detector_bank.sv
// Summary of operation
// RQ1: Rise follows one minus exponential, fall follows decaying exponential.
// RQ2: Four laws selectable; exactly one drives the level result.
// RQ3: Realtime law has zero rise and fall constants.
// RQ4: Realtime result is input sampled when measuring time expires.
// RQ5: Peak law follows a rising input immediately.
// RQ6: Peak law decays slowly with a long fall constant.
// RQ7: Linear mean law uses one constant for rise and fall.
// RQ8: Linear mean averages linear input magnitude.
// RQ9: Power mean squares the input before smoothing.
// RQ10: Power mean takes square root after smoothing.
// RQ11: Power mean uses one common constant for rise and fall.
// RQ12: Offset goes through the linear mean smoother.
// RQ13: Deviation goes through the peak smoother.
// RQ14: Service request marker sent anytime, even inside a response; code sends it only between bytes from idle, not inside a poll reply.
// RQ15: Marker sent only on inactive-to-active request edge.
// RQ16: Poll string answered with ampersand, decimal status byte, CR LF.
// RQ17: Clear-status resets status system; reset restores default settings.
// RQ18: Every query response ends with a linefeed.
// RQ19: Per-sample first-order recursion, coefficient chosen by comparing input and output.
`include "level_detector_map.svh"

module level_detector_bank
    import level_detector_pkg::*;
#(
    parameter int DW = `LD_DATA_W
) (
    // Clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      sys_rst,
    // Samples
    input  wire logic                      sampleValid,
    input  wire logic signed [DW-1:0]      levelIn,
    input  wire logic signed [DW-1:0]      offsetIn,
    input  wire logic        [DW-1:0]      deviationIn,
    input  wire logic                      measureDone,
    input  wire logic                      detClear,
    // Settings
    input  wire level_detector_pkg::law_t  lawSel,
    input  wire logic                      lawWrite,
    input  wire logic        [15:0]        meanCoefIn,
    input  wire logic        [15:0]        peakFallIn,
    input  wire logic                      coefWrite,
    input  wire logic                      defaultsCmd,
    // Status
    input  wire logic                      srqCond,
    input  wire logic        [7:0]         statusIn,
    input  wire logic                      clearStatusCmd,
    // Control stream in and out
    input  wire logic                      rxValid,
    input  wire logic        [7:0]         rxByte,
    input  wire logic                      respValid,
    input  wire logic        [7:0]         respByte,
    input  wire logic                      respLast,
    output logic                           respReady,
    output logic                           txValid,
    output logic             [7:0]         txByte,
    input  wire logic                      txReady,
    // Results
    output logic             [DW-1:0]      levelOut,
    output logic             [DW-1:0]      offsetOut,
    output logic             [DW-1:0]      deviationOut,
    output logic             [7:0]         statusOut
);
    // ==========================================================
    // Settings
    law_t        law_r;
    logic [15:0] meanCoef_r, peakFall_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst || defaultsCmd) begin                          // RQ17
            law_r      <= LAW_PEAK;
            meanCoef_r <= `LD_MEAN_DEF;
            peakFall_r <= `LD_PEAK_FALL_DEF;
        end else begin
            if (lawWrite)
                law_r <= lawSel;                                   // RQ2
            if (coefWrite) begin
                meanCoef_r <= meanCoefIn == 16'h0000 ? `LD_MEAN_DEF : meanCoefIn;
                peakFall_r <= peakFallIn;
            end
        end
    end

    // ==========================================================
    // Detector inputs
    logic [DW-1:0]   mag, offMag;
    logic [2*DW-1:0] power;
    always_comb begin
        mag    = levelIn[DW-1] ? DW'(-levelIn) : DW'(levelIn);     // RQ8
        offMag = offsetIn[DW-1] ? DW'(-offsetIn) : DW'(offsetIn);
        power  = (2*DW)'(mag) * (2*DW)'(mag);                      // RQ9
    end

    logic [DW-1:0]   peakS, meanS, offS, devS;
    logic [2*DW-1:0] powS;

    // Zero time constant rise and slow fall
    exp_smoother #(.W(DW)) uPeak (
        .core_clk(core_clk), .sys_rst(sys_rst), .clear(detClear),
        .sampleValid(sampleValid), .sampleIn(mag),
        .riseCoef(`LD_COEF_FULL), .fallCoef(peakFall_r),           // RQ5 RQ6
        .smoothOut(peakS));
    exp_smoother #(.W(DW)) uMean (
        .core_clk(core_clk), .sys_rst(sys_rst), .clear(detClear),
        .sampleValid(sampleValid), .sampleIn(mag),
        .riseCoef(meanCoef_r), .fallCoef(meanCoef_r),              // RQ7
        .smoothOut(meanS));
    exp_smoother #(.W(2*DW)) uPow (
        .core_clk(core_clk), .sys_rst(sys_rst), .clear(detClear),
        .sampleValid(sampleValid), .sampleIn(power),
        .riseCoef(meanCoef_r), .fallCoef(meanCoef_r),              // RQ11
        .smoothOut(powS));
    exp_smoother #(.W(DW)) uOff (
        .core_clk(core_clk), .sys_rst(sys_rst), .clear(detClear),
        .sampleValid(sampleValid), .sampleIn(offMag),
        .riseCoef(meanCoef_r), .fallCoef(meanCoef_r),              // RQ12
        .smoothOut(offS));
    exp_smoother #(.W(DW)) uDev (
        .core_clk(core_clk), .sys_rst(sys_rst), .clear(detClear),
        .sampleValid(sampleValid), .sampleIn(deviationIn),
        .riseCoef(`LD_COEF_FULL), .fallCoef(peakFall_r),           // RQ13
        .smoothOut(devS));

    // ==========================================================
    // Square root, one result bit per cycle; slow but cheap
    logic [2*DW-1:0] sqRem_r;
    logic [DW-1:0]   sqRoot_r, sqRes_r;
    logic [$clog2(DW+1)-1:0] sqBit_r;
    logic [DW-1:0]   trial;
    always_comb trial = sqRoot_r | (DW'(1) << (sqBit_r - 1'b1));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sqBit_r  <= '0;
            sqRem_r  <= '0;
            sqRoot_r <= '0;
            sqRes_r  <= '0;
        end else if (sqBit_r == 0) begin
            sqRes_r  <= sqRoot_r;                                  // RQ10
            sqRem_r  <= powS;
            sqRoot_r <= '0;
            sqBit_r  <= ($clog2(DW+1))'(DW);
        end else begin
            if (trial * trial <= sqRem_r)
                sqRoot_r <= trial;
            sqBit_r <= sqBit_r - 1'b1;
        end
    end

    // ==========================================================
    // Result selection
    logic [DW-1:0] fast_r;
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fast_r       <= '0;
            levelOut     <= '0;
            offsetOut    <= '0;
            deviationOut <= '0;
        end else begin
            if (measureDone)
                fast_r <= mag;                                     // RQ3 RQ4
            case (law_r)                                           // RQ2
                LAW_REALTIME:    levelOut <= fast_r;
                LAW_PEAK:        levelOut <= peakS;
                LAW_LINEAR_MEAN: levelOut <= meanS;
                LAW_POWER_MEAN:  levelOut <= sqRes_r;
                default:         levelOut <= peakS;
            endcase
            offsetOut    <= offS;
            deviationOut <= devS;
        end
    end

    // ==========================================================
    // Status and request edge
    logic srqPrev_r, srqPend_r, polPend_r;
    logic [2:0] polMatch_r;
    logic srqTake, polTake;

    always_ff @(posedge core_clk) begin
        if (sys_rst || clearStatusCmd) begin                       // RQ17
            statusOut <= 8'h00;
            srqPrev_r <= 1'b0;
        end else begin
            statusOut <= statusIn;
            srqPrev_r <= srqCond;
        end
    end

    // Set wins over the take
    always_ff @(posedge core_clk) begin
        if (sys_rst || clearStatusCmd)
            srqPend_r <= 1'b0;
        else if (srqCond && !srqPrev_r)
            srqPend_r <= 1'b1;                                     // RQ15
        else if (srqTake)
            srqPend_r <= 1'b0;
    end

    // Poll detector "&POL"
    logic [7:0] polChar;
    always_comb begin
        case (polMatch_r)
            3'd0:    polChar = `LD_CHAR_AMP;
            3'd1:    polChar = 8'h50;
            3'd2:    polChar = 8'h4F;
            3'd3:    polChar = 8'h4C;
            default: polChar = 8'h00;
        endcase
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            polMatch_r <= '0;
            polPend_r  <= 1'b0;
        end else begin
            if (rxValid) begin
                if (rxByte == polChar && polMatch_r == 3'd3) begin
                    polMatch_r <= '0;
                    polPend_r  <= 1'b1;                            // RQ16
                end else if (rxByte == polChar)
                    polMatch_r <= polMatch_r + 3'd1;
                else
                    polMatch_r <= rxByte == `LD_CHAR_AMP ? 3'd1 : 3'd0;
            end
            if (polTake && !(rxValid && rxByte == polChar && polMatch_r == 3'd3))
                polPend_r <= 1'b0;
        end
    end

    // ==========================================================
    // Transmit stream: marker or poll reply inserted between bytes
    typedef enum {TX_IDLE, TX_SRQ, TX_POL, TX_RESP} tx_t;
    tx_t tx_r;
    logic [2:0] idx_r;
    logic [7:0] srqChar, polReply, stat_r;
    logic txBusy;
    assign txBusy = txValid && !txReady;
    assign srqTake = tx_r == TX_IDLE && !txBusy && srqPend_r;
    assign polTake = tx_r == TX_IDLE && !txBusy && !srqPend_r && polPend_r;

    always_comb begin
        case (idx_r)
            3'd0:    srqChar = `LD_CHAR_AMP;
            3'd1:    srqChar = 8'h53;
            3'd2:    srqChar = 8'h52;
            3'd3:    srqChar = 8'h51;
            3'd4:    srqChar = `LD_CHAR_CR;
            default: srqChar = `LD_CHAR_LF;
        endcase
        case (idx_r)
            3'd0:    polReply = `LD_CHAR_AMP;
            3'd1:    polReply = 8'h30 + 8'(stat_r / 8'd100);
            3'd2:    polReply = 8'h30 + 8'((stat_r / 8'd10) % 8'd10);
            3'd3:    polReply = 8'h30 + 8'(stat_r % 8'd10);
            3'd4:    polReply = `LD_CHAR_CR;
            default: polReply = `LD_CHAR_LF;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_r      <= TX_IDLE;
            idx_r     <= '0;
            stat_r    <= '0;
            txValid   <= 1'b0;
            txByte    <= 8'h00;
            respReady <= 1'b0;
        end else begin
            respReady <= 1'b0;
            if (txValid && txReady)
                txValid <= 1'b0;
            case (tx_r)
                TX_IDLE: if (!txBusy) begin
                    idx_r <= '0;
                    if (srqPend_r)
                        tx_r <= TX_SRQ;                            // RQ14
                    else if (polPend_r) begin
                        tx_r   <= TX_POL;
                        stat_r <= statusOut;
                    end else if (respValid && !respReady) begin
                        respReady <= 1'b1;
                        tx_r      <= TX_RESP;
                    end
                end
                TX_SRQ: if (!txBusy) begin
                    txValid <= 1'b1;
                    txByte  <= srqChar;
                    idx_r   <= idx_r + 3'd1;
                    if (idx_r == 3'(`LD_SRQ_LEN - 1))
                        tx_r <= TX_IDLE;
                end
                TX_POL: if (!txBusy) begin
                    txValid <= 1'b1;
                    txByte  <= polReply;                           // RQ16
                    idx_r   <= idx_r + 3'd1;
                    if (idx_r == 3'd5)
                        tx_r <= TX_IDLE;
                end
                TX_RESP: begin
                    txValid <= 1'b1;
                    txByte  <= respByte;
                    // Query response closes with a linefeed
                    tx_r <= TX_IDLE;
                    if (respLast) begin
                        tx_r  <= TX_POL;
                        idx_r <= 3'd5;                             // RQ18
                    end
                end
                default: tx_r <= TX_IDLE;
            endcase
        end
    end
endmodule : level_detector_bank

// file: sim/level_detector_bank_properties.sv
`include "level_detector_map.svh"
// ==========================================
// Port checks for the detector bank
module level_detector_bank_properties
    import level_detector_pkg::*;
#(
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic                     core_clk,
    input wire logic                     sys_rst,
    // Inputs
    input wire logic                     sampleValid,
    input wire logic signed [DW-1:0]     levelIn,
    input wire logic        [DW-1:0]     deviationIn,
    input wire logic                     measureDone,
    input wire logic                     detClear,
    input wire level_detector_pkg::law_t lawSel,
    input wire logic                     lawWrite,
    input wire logic                     defaultsCmd,
    input wire logic                     srqCond,
    input wire logic                     txReady,
    // Outputs
    input wire logic                     respReady,
    input wire logic                     txValid,
    input wire logic        [7:0]        txByte,
    input wire logic        [DW-1:0]     levelOut,
    input wire logic        [DW-1:0]     deviationOut
);
    timeunit 1ns;
    timeprecision 100ps;

    law_t          curLaw_r;
    logic [DW-1:0] lvlCap_r;
    logic [DW-1:0] devCap_r;

    always_ff @(posedge core_clk) begin
        if (sys_rst || defaultsCmd) begin
            curLaw_r <= LAW_PEAK;
        end else if (lawWrite) begin
            curLaw_r <= lawSel;
        end
    end

    // Held inputs, so a late output is still compared with its own cause
    always_ff @(posedge core_clk) begin
        if (sampleValid || measureDone) begin
            lvlCap_r <= levelIn;
            devCap_r <= deviationIn;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_reset_clears: assert property (disable iff (1'b0)
        sys_rst |=> levelOut == '0 && !txValid) else $error("outputs not cleared by reset");
    chk_peak_rise: assert property (
        curLaw_r == LAW_PEAK && sampleValid && !detClear && !levelIn[DW-1]
        |=> ##[0:2] levelOut >= lvlCap_r) else $error("peak level lags a rise");
    chk_realtime_latch: assert property (
        curLaw_r == LAW_REALTIME && measureDone && !sampleValid && !levelIn[DW-1]
        |=> ##[0:2] levelOut == lvlCap_r) else $error("realtime level not latched");
    chk_deviation_peak: assert property (
        sampleValid && !detClear |=> ##[0:2] deviationOut >= devCap_r)
        else $error("deviation lags a rise");
    chk_tx_holds: assert property (
        txValid && !txReady |=> txValid && $stable(txByte)) else $error("tx byte dropped");
    chk_srq_marker: assert property (
        $rose(srqCond) |-> ##[1:60] txValid && txByte == `LD_CHAR_AMP)
        else $error("no marker after request edge");
    chk_cr_then_lf: assert property (
        txValid && txReady && txByte == `LD_CHAR_CR |-> ##[1:60] txValid && txByte == `LD_CHAR_LF)
        else $error("line not closed by linefeed");
    chk_resp_pulse: assert property (
        respReady |=> !respReady) else $error("response ready longer than one cycle");
endmodule : level_detector_bank_properties

bind level_detector_bank level_detector_bank_properties #(.DW(DW)) u_props (.*);

// file: sim/host_model.sv
// ==========================================
// Remote host: strips markers, keeps last line, sends polls
module host_model (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    // Bench control
    input  wire logic       slow,
    input  wire logic       sendPoll,
    output int              srqCount,
    output logic [39:0]     lastLine,
    // Control stream
    input  wire logic       txValid,
    input  wire logic [7:0] txByte,
    output logic            txReady,
    output logic            rxValid,
    output logic [7:0]      rxByte
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0]  stall_r;
    logic [2:0]  pollIdx_r;
    logic [95:0] hist_r;
    logic [95:0] histNext;
    logic [31:0] pollWord;

    always_ff @(posedge core_clk) begin
        stall_r <= sys_rst ? 2'h0 : stall_r + 2'h1;
    end

    // A slow host takes one byte in four
    assign txReady = !slow || stall_r == 2'h3;
    assign histNext = {hist_r[87:0], txByte};

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hist_r <= '0;
            srqCount <= 0;
            lastLine <= '0;
        end else if (txValid && txReady) begin
            if (histNext[47:0] == {"&SRQ", 8'h0D, 8'h0A}) begin
                srqCount <= srqCount + 1;
                hist_r <= hist_r >> 40;
            end else begin
                hist_r <= histNext;
                if (txByte == 8'h0A) begin
                    lastLine <= hist_r[39:0];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pollIdx_r <= 3'h0;
        end else if (sendPoll) begin
            pollIdx_r <= 3'h4;
        end else if (pollIdx_r != 3'h0) begin
            pollIdx_r <= pollIdx_r - 3'h1;
        end
    end

    assign pollWord = 32'h26504F4C >> {pollIdx_r - 3'h1, 3'h0};
    assign rxValid = pollIdx_r != 3'h0;
    // Idle line moves every cycle so a stale byte never looks valid
    assign rxByte = rxValid ? pollWord[7:0] : {stall_r, 6'h15};
endmodule : host_model

// file: sim/testbench.sv
// ==========================================
// Self-checking bench for the detector bank
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import level_detector_pkg::*;

    localparam int DW = 16;
    logic                 core_clk, sys_rst, sampleValid, measureDone, detClear;
    logic signed [DW-1:0] levelIn, offsetIn;
    logic [DW-1:0]        deviationIn, levelOut, offsetOut, deviationOut;
    logic [15:0]          meanCoefIn, peakFallIn;
    law_t                 lawSel;
    logic                 lawWrite, coefWrite, defaultsCmd, srqCond, clearStatusCmd;
    logic                 rxValid, respValid, respLast, respReady, txValid, txReady;
    logic                 slow, sendPoll;
    logic [7:0]           statusIn, rxByte, respByte, txByte, statusOut;
    logic [39:0]          lastLine;
    int                   srqCount, errCount, samplesChecked;

    typedef struct packed {
        law_t        law;
        logic [15:0] inV;
        logic [15:0] expV;
    } row_t;
    row_t rows [4] = '{
        '{LAW_REALTIME, 16'h012C, 16'h012C},
        '{LAW_PEAK, 16'h03E8, 16'h03E8},
        '{LAW_LINEAR_MEAN, 16'hFE0C, 16'h01F4},
        '{LAW_POWER_MEAN, 16'hFD44, 16'h02BC}
    };

    level_detector_bank #(.DW(DW)) DUT (.*);
    host_model u_host (.*);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick

    task automatic check(input string name, input logic [39:0] lo, hi, got);
        samplesChecked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            $display("wrong value %s expected %0d..%0d seen %0d", name, lo, hi, got);
            errCount++;
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic setup(input law_t law, input logic [15:0] coef);
        lawSel = law;
        meanCoefIn = coef;
        {lawWrite, coefWrite, detClear} = 3'h7;
        tick(1);
        {lawWrite, coefWrite, detClear} = 3'h0;
        tick(1);
    endtask : setup

    // Long gap covers the square-root iterations
    task automatic sample(input logic [15:0] v);
        levelIn = $signed(v);
        sampleValid = 1'b1;
        tick(1);
        sampleValid = 1'b0;
        tick(2 * DW + 8);
    endtask : sample

    task automatic send_resp(input logic [7:0] b, input logic last);
        int i;
        {respValid, respByte, respLast} = {1'b1, b, last};
        for (i = 0; i < 400; i++) begin
            @(posedge core_clk);
            if (respReady === 1'b1) break;
        end
        #2;
        respValid = 1'b0;
        if (i == 400) begin
            errCount++;
            report_and_stop();
        end
    endtask : send_resp

    // Zero line means only the marker count is awaited
    task automatic wait_host(input int n, input logic [39:0] line);
        int i;
        for (i = 0; i < 400 && !(srqCount == n && (line == '0 || lastLine === line)); i++) begin
            tick(1);
        end
        if (i == 400) begin
            errCount++;
            report_and_stop();
        end
    endtask : wait_host

    initial begin
        int r;
        {sampleValid, measureDone, detClear, lawWrite, coefWrite, defaultsCmd} = '0;
        {srqCond, clearStatusCmd, respValid, respLast, slow, sendPoll} = '0;
        {levelIn, offsetIn, deviationIn} = {16'h0000, 16'h00C8, 16'h0384};
        lawSel = LAW_PEAK;
        {meanCoefIn, peakFallIn} = {16'hFFFF, 16'h0010};
        {statusIn, respByte, errCount, samplesChecked} = {8'h25, 8'h00, 32'd0, 32'd0};
        sys_rst = 1'b1;
        tick(8);
        sys_rst = 1'b0;
        check("levelOut", 0, 0, levelOut);
        check("txValid", 0, 0, txValid);
        $display("reset test done");
        for (r = 0; r < 4; r++) begin
            setup(rows[r].law, 16'hFFFF);
            sample(rows[r].inV);
            measureDone = 1'b1;
            tick(1);
            measureDone = 1'b0;
            tick(4);
            check("levelOut", rows[r].expV, rows[r].expV, levelOut);
            check("offsetOut", 16'h00C8, 16'h00C8, offsetOut);
            check("deviationOut", 16'h0384, 16'h0384, deviationOut);
        end
        $display("table test done");
        setup(LAW_LINEAR_MEAN, 16'h0400);
        sample(16'h1900);
        check("levelOut", 16'h0063, 16'h0064, levelOut);
        sample(16'h0000);
        check("levelOut", 16'h0062, 16'h0063, levelOut);
        {defaultsCmd, detClear} = 2'h3;
        tick(1);
        {defaultsCmd, detClear} = 2'h0;
        sample(16'h1388);
        check("levelOut", 16'h1388, 16'h1388, levelOut);
        sample(16'h0000);
        sample(16'h0000);
        check("levelOut", 16'h1370, 16'h1387, levelOut);
        $display("smoothing tests done");
        slow = 1'b1;
        send_resp(8'h41, 1'b0);
        srqCond = 1'b1;
        tick(1);
        send_resp(8'h42, 1'b1);
        wait_host(1, 40'h4142);
        tick(200);
        check("srqCount", 1, 1, srqCount);
        check("lastLine", 40'h4142, 40'h4142, lastLine);
        srqCond = 1'b0;
        clearStatusCmd = 1'b1;
        tick(1);
        check("statusOut", 8'h00, 8'h00, statusOut);
        clearStatusCmd = 1'b0;
        srqCond = 1'b1;
        wait_host(2, '0);
        slow = 1'b0;
        sendPoll = 1'b1;
        tick(1);
        sendPoll = 1'b0;
        wait_host(2, {"&037", 8'h0D});
        check("lastLine", {"&037", 8'h0D}, {"&037", 8'h0D}, lastLine);
        check("statusOut", 8'h25, 8'h25, statusOut);
        $display("status tests done");
        report_and_stop();
    end
endmodule : testbench
